// file: design/sdis_pkg.sv
// Package: register map, field layout, command codes and timing constants
package sdis_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int MADDR_W = 28;
    // Register indices (word addresses on the plain register port)
    localparam logic [ADDR_W-1:0] REG_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h1;
    localparam logic [ADDR_W-1:0] REG_LOW_POWER = 4'h2;
    localparam logic [ADDR_W-1:0] REG_REFRESH = 4'h3;
    localparam logic [ADDR_W-1:0] REG_DEVTYPE = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
    // Command codes of the mode field
    localparam logic [2:0] CMD_NORMAL = 3'h0;
    localparam logic [2:0] CMD_NOP = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_MODE_SET = 3'h3;
    localparam logic [2:0] CMD_REFRESH = 3'h4;
    localparam logic [2:0] CMD_EXT_SET = 3'h5;
    // Device types
    localparam logic [1:0] DEV_LPDDR1 = 2'h1;
    localparam logic [1:0] DEV_DDR2 = 2'h2;
    // Configuration register fields
    localparam int CFG_CAS_LSB = 0;
    localparam int CFG_DLL_BIT = 4;
    localparam int CFG_DRIVE_BIT = 5;
    localparam int CFG_TEMP_BIT = 6;
    localparam int CFG_OCD_LSB = 8;
    localparam int CFG_COL_LSB = 12;
    localparam int CFG_ROW_LSB = 16;
    localparam int CFG_BANK_BIT = 20;
    localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0003;
    // Low-power register fields
    localparam int LP_PASR_LSB = 0;
    localparam int LP_DS_LSB = 4;
    // Mode register address-bus layout
    localparam int MR_CAS_LSB = 4;
    localparam int MR_DLL_BIT = 8;
    localparam logic [2:0] MR_BURST_8 = 3'h3;
    localparam int A_PRE_ALL_BIT = 10;
    localparam int EMR_OCD_LSB = 7;
    localparam int EMR_TEMP_BIT = 7;
    localparam int EMR_DRIVE_BIT = 1;
    localparam int EMR_LP_DS_LSB = 5;
    // Bank selects for the extended sets
    localparam logic [1:0] BANK_EMR1 = 2'h1;
    localparam logic [1:0] BANK_EMR2 = 2'h2;
    localparam logic [1:0] BANK_EMR3 = 2'h3;
    // Refresh timer
    localparam int RTR_W = 12;
    localparam logic [RTR_W-1:0] RTR_RESET = 12'h000;
    // Timing
    localparam int CLK_MHZ = 20;
    localparam int PAUSE_US = 200;
    localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
    localparam int CNT_W = 16;
    // Command pins: {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_PRECHARGE = 4'h2;
    localparam logic [3:0] PIN_REFRESH = 4'h1;
    localparam logic [3:0] PIN_LOAD_MODE = 4'h0;
    localparam logic [3:0] PIN_DESELECT = 4'hf;
endpackage

// file: design/sdis_pause_timer.sv
// Pause timer: holds busy for a programmable number of cycles after a start pulse
`timescale 1ns/1ps
module sdis_pause_timer #(
    parameter int CYCLES = 4000,
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic start,
    output logic busy
);
    initial begin
        if (CYCLES < 1 || CYCLES >= (1 << W)) begin
            $error("sdis_pause_timer: CYCLES does not fit W");
        end
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    assign cnt_d = start ? W'(CYCLES) : (cnt_q != '0 ? cnt_q - W'(1) : cnt_q);
    assign busy = cnt_q != '0;

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// file: design/sdis_cmd_issue.sv
// Command pin driver: registers one SDRAM command for one cycle, else NOP while the clock runs and deselect while it is off
`timescale 1ns/1ps
module sdis_cmd_issue #(
    parameter int AW = 14
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request
    input wire logic issue,
    input wire logic [3:0] pins,
    input wire logic [1:0] bank,
    input wire logic [AW-1:0] addr,
    input wire logic clk_on,
    // SDRAM pins
    output logic [3:0] cmd_pins_q,
    output logic [1:0] ba_q,
    output logic [AW-1:0] a_q
);
    import sdis_pkg::*;

    always_ff @(posedge clock) begin
        if (rst) begin
            cmd_pins_q <= PIN_DESELECT;
            ba_q <= '0;
            a_q <= '0;
        end else if (issue) begin
            cmd_pins_q <= pins;
            ba_q <= bank;
            a_q <= addr;
        end else begin
            cmd_pins_q <= clk_on ? PIN_NOP : PIN_DESELECT;
        end
    end
endmodule

// file: design/sdis_init_sequencer.sv
// Software-driven SDRAM initialization command sequencer with register port
// Function
// R01: Code 1 plus memory write issues NOP and enables the SDRAM clocks.
// R02: Code 2 plus memory write issues all-banks precharge.
// R03: Code 4 issues one auto-refresh per write; software writes twice.
// R04: Code 3 write issues mode set with CAS and burst; bank bits zero.
// R05: Code 5 issues extended set; bank bits from address select the target.
// R06: LPDDR1 extended set carries PASR and drive strength from low-power register.
// R07: Code 0 plus memory write returns to normal operation.
// R08: After first NOP, pause at least 200 us before further toggles.
// R09: Software follows the LPDDR1 init order.
// R10: DDR2: CKE goes high when the second NOP is acknowledged.
// R11: Software waits 200 cycles after DLL-enable extended set.
// R12: DLL-reset bit selects DLL reset in the mode set command.
// R13: OCD field in first extended set: 7 default, 0 exit.
// R14: Software follows the DDR2 init order.
// R15: DDR2 config holds drive strength with columns, rows, banks, CAS.
// R16: Second extended set carries commercial/high-temperature selection.
// R17: Refresh count sets auto-refresh interval in clock cycles.
// R18: Software makes one extra write after normal mode before refresh rate.
// R19: In non-normal mode a memory write triggers the command only, no data.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module sdis_init_sequencer #(
    parameter int PAUSE_CYCLES = sdis_pkg::PAUSE_CYC,
    parameter int ROW_W = 14
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [sdis_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sdis_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sdis_pkg::DATA_W-1:0] reg_rdata,
    // Memory-space write from the system side
    input wire logic mem_wr,
    input wire logic [sdis_pkg::MADDR_W-1:0] mem_addr,
    output logic mem_wr_data_ok,
    output logic normal_mode,
    // SDRAM command pins and refresh request
    output logic sdram_clk_en,
    output logic sdram_cke,
    output logic [3:0] sdram_cmd,
    output logic [1:0] sdram_ba,
    output logic [ROW_W-1:0] sdram_a,
    output logic refresh_req
);
    import sdis_pkg::*;

    initial begin
        if (ROW_W < 13 || ROW_W > 16) begin
            $error("sdis_init_sequencer: ROW_W must be 13 to 16");
        end
        if (PAUSE_CYCLES < 1) begin
            $error("sdis_init_sequencer: PAUSE_CYCLES must be positive");
        end
    end

    typedef enum logic [1:0] {
        SDIS_OFF,
        SDIS_CLOCKED,
        SDIS_CKE_ON
    } sdis_pwr_t;

    // Register state
    logic [2:0] mode_q;
    logic [DATA_W-1:0] cfg_q;
    logic [7:0] lp_q;
    logic [RTR_W-1:0] rtr_q;
    logic [1:0] dev_q;
    logic [DATA_W-1:0] rdata_q;
    logic normal_q;
    sdis_pwr_t pwr_q;
    sdis_pwr_t pwr_d;
    logic [RTR_W-1:0] rcnt_q;
    logic [RTR_W-1:0] rcnt_d;
    logic refresh_q;

    // Register decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    wire wr_mode = reg_wr && hit(reg_addr, REG_MODE);
    wire wr_cfg = reg_wr && hit(reg_addr, REG_CONFIG);
    wire wr_lp = reg_wr && hit(reg_addr, REG_LOW_POWER);
    wire wr_rtr = reg_wr && hit(reg_addr, REG_REFRESH);
    wire wr_dev = reg_wr && hit(reg_addr, REG_DEVTYPE);

    // Memory-space command decode
    wire [1:0] wr_bank = mem_addr[MADDR_W-2 +: 2];
    wire pause_busy;
    // Toggles are held back while the pause runs; the write is still acknowledged
    wire cmd_ok = mem_wr && !pause_busy; // R08
    wire is_nop = cmd_ok && mode_q == CMD_NOP;
    wire is_pre = cmd_ok && mode_q == CMD_PRECHARGE; // R02
    wire is_ref = cmd_ok && mode_q == CMD_REFRESH; // R03
    wire is_mrs = cmd_ok && mode_q == CMD_MODE_SET; // R04
    wire is_extended_mode_set = cmd_ok && mode_q == CMD_EXT_SET; // R05
    wire is_norm = mem_wr && mode_q == CMD_NORMAL; // R07
    wire first_nop = mem_wr && mode_q == CMD_NOP && pwr_q == SDIS_OFF;
    wire is_ddr2 = dev_q == DEV_DDR2;

    // Mode set word: burst 8, CAS latency, DLL reset
    logic [ROW_W-1:0] mrs_word;
    always_comb begin
        mrs_word = '0;
        mrs_word[2:0] = MR_BURST_8; // R04
        mrs_word[MR_CAS_LSB +: 3] = cfg_q[CFG_CAS_LSB +: 3]; // R04
        mrs_word[MR_DLL_BIT] = is_ddr2 && cfg_q[CFG_DLL_BIT]; // R12
    end

    // Extended set word, chosen by device type and target bank
    logic [ROW_W-1:0] extended_mode_set_word;
    always_comb begin
        extended_mode_set_word = '0;
        if (!is_ddr2) begin
            extended_mode_set_word[2:0] = lp_q[LP_PASR_LSB +: 3]; // R06
            extended_mode_set_word[EMR_LP_DS_LSB +: 2] = lp_q[LP_DS_LSB +: 2]; // R06
        end else begin
            case (wr_bank)
                BANK_EMR1: begin
                    extended_mode_set_word[EMR_DRIVE_BIT] = cfg_q[CFG_DRIVE_BIT]; // R15
                    extended_mode_set_word[EMR_OCD_LSB +: 3] = cfg_q[CFG_OCD_LSB +: 3]; // R13
                end
                BANK_EMR2: extended_mode_set_word[EMR_TEMP_BIT] = cfg_q[CFG_TEMP_BIT]; // R16
                BANK_EMR3: extended_mode_set_word = '0;
                default: extended_mode_set_word = '0;
            endcase
        end
    end

    // Command selection
    wire issue = is_nop || is_pre || is_ref || is_mrs || is_extended_mode_set; // R19
    wire [3:0] pins_sel = (is_pre) ? PIN_PRECHARGE :
                          (is_ref) ? PIN_REFRESH :
                          (is_mrs || is_extended_mode_set) ? PIN_LOAD_MODE : PIN_NOP;
    wire [1:0] bank_sel = is_mrs ? 2'h0 : wr_bank;
    wire [ROW_W-1:0] a_sel = is_pre ? ROW_W'(1 << A_PRE_ALL_BIT) :
                             is_mrs ? mrs_word :
                             is_extended_mode_set ? extended_mode_set_word : '0;

    // Power-up progression of clock and CKE
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            SDIS_OFF: begin
                if (first_nop) begin
                    pwr_d = is_ddr2 ? SDIS_CLOCKED : SDIS_CKE_ON; // R01
                end
            end
            SDIS_CLOCKED: begin
                if (is_nop) begin
                    pwr_d = SDIS_CKE_ON; // R10
                end
            end
            SDIS_CKE_ON: pwr_d = pwr_q;
            default: pwr_d = SDIS_OFF;
        endcase
    end

    // Refresh interval counter runs only in normal mode with a nonzero count
    wire rcnt_zero = rcnt_q == '0;
    // Reload with count minus one so a count of N gives one request every N cycles
    assign rcnt_d = (!normal_q || rtr_q == '0) ? '0 :
                    rcnt_zero ? rtr_q - RTR_W'(1) : rcnt_q - RTR_W'(1); // R17

    // Read mux
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            REG_MODE: rd_mux[2:0] = mode_q;
            REG_CONFIG: rd_mux = cfg_q;
            REG_LOW_POWER: rd_mux[7:0] = lp_q;
            REG_REFRESH: rd_mux[RTR_W-1:0] = rtr_q;
            REG_DEVTYPE: rd_mux[1:0] = dev_q;
            REG_STATUS: rd_mux[3:0] = {pause_busy, normal_q, sdram_cke, sdram_clk_en};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= CMD_NORMAL;
            cfg_q <= CFG_RESET;
            lp_q <= '0;
            dev_q <= DEV_DDR2;
            rdata_q <= '0;
        end else begin
            if (wr_mode) mode_q <= reg_wdata[2:0];
            if (wr_cfg) cfg_q <= reg_wdata; // R15
            if (wr_lp) lp_q <= reg_wdata[7:0];
            if (wr_dev) dev_q <= reg_wdata[1:0];
            rdata_q <= reg_rd ? rd_mux : '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rtr_q <= RTR_RESET;
            normal_q <= 1'b0;
            pwr_q <= SDIS_OFF;
            rcnt_q <= RTR_RESET;
            refresh_q <= 1'b0;
        end else begin
            if (wr_rtr) rtr_q <= reg_wdata[RTR_W-1:0]; // R17
            if (is_norm) normal_q <= 1'b1; // R07
            else if (wr_mode && reg_wdata[2:0] != CMD_NORMAL) normal_q <= 1'b0;
            pwr_q <= pwr_d;
            rcnt_q <= rcnt_d;
            refresh_q <= normal_q && rtr_q != '0 && rcnt_zero; // R17
        end
    end

    sdis_pause_timer #(
        .CYCLES(PAUSE_CYCLES),
        .W(CNT_W)
    ) u_pause (
        .clock(clock),
        .rst(rst),
        .start(first_nop), // R08
        .busy(pause_busy)
    );

    sdis_cmd_issue #(
        .AW(ROW_W)
    ) u_issue (
        .clock(clock),
        .rst(rst),
        .issue(issue),
        .pins(pins_sel),
        .bank(bank_sel),
        .addr(a_sel),
        .clk_on(sdram_clk_en),
        .cmd_pins_q(sdram_cmd),
        .ba_q(sdram_ba),
        .a_q(sdram_a)
    );

    assign reg_rdata = rdata_q;
    assign sdram_clk_en = pwr_q != SDIS_OFF; // R01
    assign sdram_cke = pwr_q == SDIS_CKE_ON; // R10
    assign normal_mode = normal_q;
    // Write data reach the array only in normal mode
    assign mem_wr_data_ok = mem_wr && mode_q == CMD_NORMAL && normal_q; // R19
    assign refresh_req = refresh_q;
endmodule

// file: bench/sdis_sdram_model.sv
// SDRAM device model: decodes the command pins and keeps mode register images
`timescale 1ns/1ps
module sdis_sdram_model #(
    parameter int AW = 14
) (
    // Clock and command pins
    input wire logic clock,
    input wire logic clk_en,
    input wire logic [3:0] cmd,
    input wire logic [1:0] ba,
    input wire logic [AW-1:0] a
);
    import sdis_pkg::*;
    logic [AW-1:0] mr_q [4];
    int refs_q = 0;
    // Pins mean nothing while the device clock is stopped
    always @(posedge clock) begin
        if (clk_en && cmd == PIN_LOAD_MODE) begin
            mr_q[ba] <= a;
        end
        if (clk_en && cmd == PIN_REFRESH) begin
            refs_q <= refs_q + 1;
        end
    end
endmodule

// file: bench/sdis_checker.sv
// Port checker for the SDRAM init command sequencer
`timescale 1ns/1ps
module sdis_checker #(
    parameter int PAUSE_CYCLES = 4000,
    parameter int ROW_W = 14
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register and memory side
    input wire logic reg_rd,
    input wire logic [sdis_pkg::DATA_W-1:0] reg_rdata,
    input wire logic mem_wr,
    input wire logic mem_wr_data_ok,
    input wire logic normal_mode,
    // SDRAM pins
    input wire logic sdram_clk_en,
    input wire logic sdram_cke,
    input wire logic [3:0] sdram_cmd,
    input wire logic [1:0] sdram_ba,
    input wire logic [ROW_W-1:0] sdram_a,
    input wire logic refresh_req
);
    import sdis_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic clk_en_q;
    logic [15:0] pcnt_q;
    logic [15:0] pcnt_d;
    wire clk_rise = sdram_clk_en && !clk_en_q;
    // Two cycles of slack at the end of the pause avoid a boundary guess
    assign pcnt_d = clk_rise ? 16'(PAUSE_CYCLES - 2) :
                    (pcnt_q != 16'h0 ? pcnt_q - 16'h1 : 16'h0);
    always_ff @(posedge clock) begin
        clk_en_q <= rst ? 1'h0 : sdram_clk_en;
        pcnt_q <= rst ? 16'h0 : pcnt_d;
    end
    sequence s_issue;
        sdram_cmd != PIN_NOP && sdram_cmd != PIN_DESELECT && !mem_wr;
    endsequence
    sequence s_took_write;
        sdram_clk_en && $past(mem_wr);
    endsequence
    property p_one_cycle;
        s_issue |=> sdram_cmd == PIN_NOP;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("command stood too long");
    property p_clk_on;
        $rose(sdram_clk_en) |-> sdram_cmd == PIN_NOP ##0 s_took_write;
    endproperty
    a_clk_on: assert property (p_clk_on) else $error("clock enable without nop");
    property p_clk_stays;
        sdram_clk_en |=> sdram_clk_en;
    endproperty
    a_clk_stays: assert property (p_clk_stays) else $error("clock enable dropped");
    property p_pause;
        pcnt_q != 0 |-> sdram_cmd == PIN_NOP;
    endproperty
    a_pause: assert property (p_pause) else $error("command during pause");
    property p_prech;
        sdram_cmd == PIN_PRECHARGE |-> sdram_a[10];
    endproperty
    a_prech: assert property (p_prech) else $error("precharge not all banks");
    property p_mode;
        sdram_cmd == PIN_LOAD_MODE && sdram_ba == 2'h0 |-> sdram_a[2:0] == MR_BURST_8;
    endproperty
    a_mode: assert property (p_mode) else $error("mode set burst wrong");
    property p_cke;
        $rose(sdram_cke) |-> s_took_write;
    endproperty
    a_cke: assert property (p_cke) else $error("cke rose without write");
    property p_data_ok;
        mem_wr_data_ok |-> mem_wr && normal_mode;
    endproperty
    a_data_ok: assert property (p_data_ok) else $error("data passed outside normal");
    property p_refresh;
        refresh_req |-> $past(normal_mode) ##1 !refresh_req;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh pulse wrong");
    property p_rdata;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule
bind sdis_init_sequencer sdis_checker #(.PAUSE_CYCLES(PAUSE_CYCLES), .ROW_W(ROW_W)) sdis_checker_i (
    .clock, .rst, .reg_rd, .reg_rdata, .mem_wr, .mem_wr_data_ok, .normal_mode,
    .sdram_clk_en, .sdram_cke, .sdram_cmd, .sdram_ba, .sdram_a, .refresh_req
);

// file: bench/test_sdis_init_sequencer.sv
// Self-checking bench for the SDRAM init command sequencer
`timescale 1ns/1ps
module test_sdis_init_sequencer;
    import sdis_pkg::*;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [3:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic mem_wr = 1'h0;
    logic [27:0] mem_addr = '0;
    wire [31:0] reg_rdata;
    wire mem_wr_data_ok, normal_mode, sdram_clk_en, sdram_cke, refresh_req;
    wire [3:0] sdram_cmd;
    wire [1:0] sdram_ba;
    wire [13:0] sdram_a;
    logic nm = 1'h0;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    // Short pause keeps the run brief; the checker gets the same value by bind
    sdis_init_sequencer #(.PAUSE_CYCLES(8)) sdis_init_sequencer_i (
        .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_wr,
        .mem_addr, .mem_wr_data_ok, .normal_mode, .sdram_clk_en, .sdram_cke,
        .sdram_cmd, .sdram_ba, .sdram_a, .refresh_req
    );
    sdis_sdram_model sdis_sdram_model_i (
        .clock, .clk_en(sdram_clk_en), .cmd(sdram_cmd), .ba(sdram_ba), .a(sdram_a)
    );
    initial begin
        forever #25 clock = ~clock;
    end
    task close_out;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            close_out;
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [3:0] ad, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= ad;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, e);
    endtask
    task mw(input logic [2:0] c, input logic [1:0] b);
        wr(REG_MODE, {29'h0, c});
        @(posedge clock);
        mem_wr <= 1'h1;
        mem_addr <= {b, 26'h0};
        #1 chk(mem_wr_data_ok, c == CMD_NORMAL && nm);
        @(posedge clock);
        mem_wr <= 1'h0;
        #1 nm = (c == CMD_NORMAL);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'h0;
        rd(REG_MODE, 32'h0);
        rd(REG_CONFIG, CFG_RESET);
        rd(4'hf, 32'h0);
        chk({sdram_clk_en, sdram_cmd}, {1'h0, PIN_DESELECT});
        wr(REG_CONFIG, 32'h63);
        rd(REG_CONFIG, 32'h63);
        mw(CMD_NOP, 2'h0);
        chk({sdram_clk_en, sdram_cke, sdram_cmd}, {2'h2, PIN_NOP});
        mw(CMD_PRECHARGE, 2'h0);
        chk(sdram_cmd, PIN_NOP);
        repeat (8) @(posedge clock);
        mw(CMD_NOP, 2'h0);
        chk(sdram_cke, 1'h1);
        mw(CMD_PRECHARGE, 2'h0);
        chk({sdram_cmd, sdram_a[10]}, {PIN_PRECHARGE, 1'h1});
        mw(CMD_EXT_SET, 2'h2);
        chk({sdram_cmd, sdram_ba, sdram_a[7]}, {PIN_LOAD_MODE, 3'h5});
        mw(CMD_EXT_SET, 2'h3);
        chk({sdram_ba, sdram_a}, {2'h3, 14'h0});
        mw(CMD_EXT_SET, 2'h1);
        chk({sdram_ba, sdram_a[1], sdram_a[9:7]}, {2'h1, 1'h1, 3'h0});
        repeat (200) @(posedge clock);
        wr(REG_CONFIG, 32'h73);
        mw(CMD_MODE_SET, 2'h0);
        chk({sdram_ba, sdram_a[8], sdram_a[6:4]}, {2'h0, 1'h1, 3'h3});
        mw(CMD_PRECHARGE, 2'h0);
        for (int i = 0; i < 2; i++) begin
            mw(CMD_REFRESH, 2'h0);
            chk(sdram_cmd, PIN_REFRESH);
        end
        @(posedge clock);
        #1 chk(sdis_sdram_model_i.refs_q, 32'h2);
        wr(REG_CONFIG, 32'h63);
        mw(CMD_MODE_SET, 2'h0);
        @(posedge clock);
        #1 chk(sdis_sdram_model_i.mr_q[0][8], 1'h0);
        wr(REG_CONFIG, 32'h763);
        mw(CMD_EXT_SET, 2'h1);
        chk(sdram_a[9:7], 3'h7);
        wr(REG_CONFIG, 32'h63);
        mw(CMD_EXT_SET, 2'h1);
        @(posedge clock);
        #1 chk(sdis_sdram_model_i.mr_q[1][9:7], 3'h0);
        mw(CMD_NORMAL, 2'h0);
        chk({sdram_cmd, normal_mode}, {PIN_NOP, 1'h1});
        mw(CMD_NORMAL, 2'h1);
        wr(REG_REFRESH, 32'h3);
        n = 0;
        repeat (40) begin
            @(posedge clock);
            #1 n += refresh_req;
        end
        chk(n, 32'he);
        wr(REG_MODE, 32'h1);
        #1 chk(normal_mode, 1'h0);
        @(posedge clock);
        rst <= 1'h1;
        repeat (10) @(posedge clock);
        rst <= 1'h0;
        nm = 1'h0;
        wr(REG_DEVTYPE, {30'h0, DEV_LPDDR1});
        wr(REG_LOW_POWER, 32'h25);
        mw(CMD_NOP, 2'h0);
        chk({sdram_clk_en, sdram_cke}, 2'h3);
        rd(REG_STATUS, 32'hb);
        repeat (10) @(posedge clock);
        mw(CMD_PRECHARGE, 2'h0);
        for (int i = 0; i < 2; i++) begin
            mw(CMD_REFRESH, 2'h0);
        end
        mw(CMD_EXT_SET, 2'h2);
        chk({sdram_ba, sdram_a[6:5], sdram_a[2:0]}, {2'h2, 2'h2, 3'h5});
        mw(CMD_MODE_SET, 2'h0);
        chk(sdram_a[2:0], MR_BURST_8);
        mw(CMD_NORMAL, 2'h0);
        mw(CMD_NORMAL, 2'h0);
        wr(REG_REFRESH, 32'h3);
        rd(REG_REFRESH, 32'h3);
        close_out;
    end
endmodule
